// ---- hdl/hsc_startup_host.sv ----
// Contract
// [R1] Bring-up runs after power-up and again after every device power-down or reset.
// [R2] Bring-up completes before any serial link configuration starts.
// [R3] Oscillator setup follows bring-up; only one oscillator usage mode at once.
// [R4] All reserved private register writes of the sequence are performed.
// [R5] Port starts three-wire; writing 0x18 to serial_port_config selects four-wire, optionally.
// [R6] Write 0x52 then 0xD2 to cal_reg_reset to reset calibration registers.
// [R7] Write 0x02 to nvm_config_a then 0x00 to nvm_config_b before loading calibration.
// [R8] Writing 0x01 to nvm_load_and_pass loads factory calibration from nonvolatile memory.
// [R9] Device sets bit 1 of nvm_load_and_pass when the boot load completes.
// [R10] Offsets chip_kind_id to grade_and_revision hold chip type, product id, grade, revision.
// [R11] After the load, write 0x03 to reference_enable to enable the reference.
// [R12] Write 0x1E to lock_loop_power to power up the clock lock loop.
// [R13] Write 0x00 to clock_receiver_ctrl to enable the clock receiver.
// [R14] Write 0x00 to converter_bias_ctrl to enable the converter bias circuits.
// [R15] Write 0x85 to the private analog parameter register analog_param_private.
// [R16] After bias and analog steps, write 0xE9 to lock_loop_enable to enable the loop.
// [R17] Device sets bit 0 of lock_loop_state on lock; host checks it before continuing.
// [R18] After lock is confirmed, write 0x20 to cal_factor_enable to enable calibration factors.
// [R19] Bits 1:0 of output_decode_select pick decode mode, written as the last step.
// [R20] Poll lock and boot-pass bits; report failure after a bounded poll count.
`timescale 1ns/1ps
module hsc_startup_host #(
  parameter int MAX_POLLS  = hsc_pkg::MAX_POLLS,
  parameter int POLL_GAP   = hsc_pkg::POLL_GAP_CYCLES,
  parameter int SCLK_HALF  = hsc_pkg::SCLK_HALF_CYCLES
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // User orders
  input  wire logic        start,
  input  wire logic        four_wire_req,
  input  wire logic        read_id_req,
  input  wire logic [1:0]  decode_mode,
  // User status
  output logic             busy,
  output logic             done,
  output logic             ready,
  output logic             fail,
  output logic [1:0]       fail_code,
  output logic [7:0]       chip_kind,
  output logic [15:0]      product_identifier,
  output logic [3:0]       product_grade_field,
  output logic [3:0]       silicon_revision_field,
  // Serial port pins
  output logic             spi_sclk,
  output logic             spi_cs_n,
  input  wire logic        sdio_in,
  output logic             sdio_out,
  output logic             sdio_oe_n,
  input  wire logic        spi_sdo
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ISSUE,
    ST_WAIT,
    ST_GAP
  } hsc_state_type;

  hsc_state_type        state;
  logic [4:0]           step_idx;
  logic [15:0]          poll_cnt;
  logic [15:0]          gap_cnt;
  logic                 fw_want;
  logic                 id_want;
  logic [1:0]           mode_q;
  logic                 four_wire_on;
  logic                 lock_seen;
  hsc_pkg::hsc_step_type cur;
  logic                 xfer_start;
  logic                 xfer_read;
  logic [7:0]           xfer_wdata;
  logic                 xfer_busy;
  logic                 xfer_done;
  logic [7:0]           xfer_rdata;
  logic                 poll_kind;
  logic                 poll_pass;
  logic                 poll_last;

  // The whole bring-up lives in one table, so the order cannot drift between paths.
  function automatic hsc_pkg::hsc_step_type step_of(input logic [4:0] idx);
    hsc_pkg::hsc_step_type s;
    s = '{hsc_pkg::STEP_WRITE, hsc_pkg::OFS_SERIAL_PORT_CONFIG, hsc_pkg::VAL_FOUR_WIRE};
    case (idx)
      5'h00: s = '{hsc_pkg::STEP_WRITE, hsc_pkg::OFS_SERIAL_PORT_CONFIG,
                   hsc_pkg::VAL_FOUR_WIRE}; // [R5]
      5'h01: s = '{hsc_pkg::STEP_WRITE, hsc_pkg::OFS_CAL_REG_RESET,
                   hsc_pkg::VAL_CAL_RESET_ON}; // [R6] [R4]
      5'h02: s = '{hsc_pkg::STEP_WRITE, hsc_pkg::OFS_CAL_REG_RESET,
                   hsc_pkg::VAL_CAL_RESET_OFF}; // [R6]
      5'h03: s = '{hsc_pkg::STEP_WRITE, hsc_pkg::OFS_NVM_CONFIG_A,
                   hsc_pkg::VAL_NVM_CONFIG_A}; // [R7] [R4]
      5'h04: s = '{hsc_pkg::STEP_WRITE, hsc_pkg::OFS_NVM_CONFIG_B,
                   hsc_pkg::VAL_NVM_CONFIG_B}; // [R7]
      5'h05: s = '{hsc_pkg::STEP_WRITE, hsc_pkg::OFS_NVM_LOAD_AND_PASS,
                   hsc_pkg::VAL_NVM_LOAD}; // [R8]
      5'h06: s = '{hsc_pkg::STEP_READ_ID, hsc_pkg::OFS_CHIP_KIND_ID, 8'h00}; // [R10]
      5'h07: s = '{hsc_pkg::STEP_READ_ID, hsc_pkg::OFS_PRODUCT_ID_LOW, 8'h00}; // [R10]
      5'h08: s = '{hsc_pkg::STEP_READ_ID, hsc_pkg::OFS_PRODUCT_ID_HIGH, 8'h00}; // [R10]
      5'h09: s = '{hsc_pkg::STEP_READ_ID, hsc_pkg::OFS_GRADE_AND_REVISION, 8'h00}; // [R10]
      5'h0a: s = '{hsc_pkg::STEP_POLL_BOOT, hsc_pkg::OFS_NVM_LOAD_AND_PASS, 8'h00}; // [R9]
      5'h0b: s = '{hsc_pkg::STEP_WRITE, hsc_pkg::OFS_REFERENCE_ENABLE,
                   hsc_pkg::VAL_REFERENCE_ON}; // [R11]
      5'h0c: s = '{hsc_pkg::STEP_WRITE, hsc_pkg::OFS_LOCK_LOOP_POWER,
                   hsc_pkg::VAL_LOOP_POWER_UP}; // [R12]
      5'h0d: s = '{hsc_pkg::STEP_WRITE, hsc_pkg::OFS_CLOCK_RECEIVER,
                   hsc_pkg::VAL_CLOCK_RX_ON}; // [R13]
      5'h0e: s = '{hsc_pkg::STEP_WRITE, hsc_pkg::OFS_CONVERTER_BIAS,
                   hsc_pkg::VAL_BIAS_ON}; // [R14]
      5'h0f: s = '{hsc_pkg::STEP_WRITE, hsc_pkg::OFS_ANALOG_PARAM,
                   hsc_pkg::VAL_ANALOG_PARAM}; // [R15] [R4]
      5'h10: s = '{hsc_pkg::STEP_WRITE, hsc_pkg::OFS_LOCK_LOOP_ENABLE,
                   hsc_pkg::VAL_LOOP_ENABLE}; // [R16]
      5'h11: s = '{hsc_pkg::STEP_POLL_LOCK, hsc_pkg::OFS_LOCK_LOOP_STATE, 8'h00}; // [R17]
      5'h12: s = '{hsc_pkg::STEP_WRITE, hsc_pkg::OFS_CAL_FACTOR_ENABLE,
                   hsc_pkg::VAL_CAL_FACTORS_ON}; // [R18]
      5'h13: s = '{hsc_pkg::STEP_DECODE, hsc_pkg::OFS_OUTPUT_DECODE, 8'h00}; // [R19]
      default: s = '{hsc_pkg::STEP_WRITE, hsc_pkg::OFS_SERIAL_PORT_CONFIG, 8'h00};
    endcase
    return s;
  endfunction

  // Optional steps are skipped without touching the pins.
  function automatic logic step_live(input logic [4:0] idx, input logic fw, input logic rid);
    logic live;
    live = 1'b1;
    if (idx == hsc_pkg::IDX_WIRE_MODE) begin
      live = fw; // [R5]
    end else if (idx >= hsc_pkg::IDX_ID_FIRST && idx <= hsc_pkg::IDX_ID_LAST) begin
      live = rid;
    end
    return live;
  endfunction

  assign cur        = step_of(step_idx);
  assign xfer_start = (state == ST_ISSUE) && step_live(step_idx, fw_want, id_want);
  assign xfer_read  = (cur.kind == hsc_pkg::STEP_READ_ID) ||
                      (cur.kind == hsc_pkg::STEP_POLL_BOOT) ||
                      (cur.kind == hsc_pkg::STEP_POLL_LOCK);
  assign xfer_wdata = (cur.kind == hsc_pkg::STEP_DECODE) ? {6'h00, mode_q} : cur.data; // [R19]
  assign poll_kind  = (cur.kind == hsc_pkg::STEP_POLL_BOOT) ||
                      (cur.kind == hsc_pkg::STEP_POLL_LOCK);
  assign poll_pass  = (cur.kind == hsc_pkg::STEP_POLL_BOOT) ?
                      xfer_rdata[hsc_pkg::BOOT_PASS_BIT] :
                      xfer_rdata[hsc_pkg::LOOP_LOCK_BIT];
  assign poll_last  = (poll_cnt == 16'(MAX_POLLS - 1));
  assign busy       = (state != ST_IDLE);

  // A fresh start with a legal decode mode replays the sequence from the first step. [R1]
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ST_IDLE;
      step_idx <= 5'h00;
      poll_cnt <= 16'h0000;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (start && decode_mode != hsc_pkg::DECODE_ILLEGAL) begin
            state    <= ST_ISSUE;
            step_idx <= 5'h00;
            poll_cnt <= 16'h0000;
          end
        end
        ST_ISSUE: begin
          if (xfer_start) begin
            state <= ST_WAIT;
          end else if (step_idx == hsc_pkg::IDX_LAST) begin
            state <= ST_IDLE;
          end else begin
            step_idx <= step_idx + 5'h01;
          end
        end
        ST_WAIT: begin
          if (xfer_done) begin
            if (poll_kind && !poll_pass) begin
              // A bounded poll count keeps a dead clock from hanging the host. [R20]
              if (poll_last) begin
                state <= ST_IDLE;
              end else begin
                state    <= ST_GAP;
                poll_cnt <= poll_cnt + 16'h0001;
              end
            end else if (step_idx == hsc_pkg::IDX_LAST) begin
              state <= ST_IDLE;
            end else begin
              state    <= ST_ISSUE;
              step_idx <= step_idx + 5'h01; // [R17] [R9]
              poll_cnt <= 16'h0000;
            end
          end
        end
        ST_GAP: begin
          if (gap_cnt == 16'h0000) begin
            state <= ST_ISSUE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt <= 16'h0000;
    end else if (state == ST_WAIT) begin
      gap_cnt <= 16'(POLL_GAP - 1);
    end else if (state == ST_GAP && gap_cnt != 16'h0000) begin
      gap_cnt <= gap_cnt - 16'h0001;
    end
  end

  // Options are latched at start so a change mid-sequence cannot split it.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fw_want <= 1'b0;
      id_want <= 1'b0;
      mode_q  <= 2'h0;
    end else if (state == ST_IDLE && start) begin
      fw_want <= four_wire_req;
      id_want <= read_id_req;
      mode_q  <= decode_mode;
    end
  end

  // A device reset returns the port to three wires, so each run starts there. [R5]
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      four_wire_on <= 1'b0;
      lock_seen    <= 1'b0;
    end else if (state == ST_IDLE && start) begin
      four_wire_on <= 1'b0;
      lock_seen    <= 1'b0;
    end else if (state == ST_WAIT && xfer_done) begin
      if (step_idx == hsc_pkg::IDX_WIRE_MODE) begin
        four_wire_on <= 1'b1;
      end
      if (cur.kind == hsc_pkg::STEP_POLL_LOCK && poll_pass) begin
        lock_seen <= 1'b1; // [R17]
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chip_kind              <= 8'h00;
      product_identifier     <= 16'h0000;
      product_grade_field    <= 4'h0;
      silicon_revision_field <= 4'h0;
    end else if (state == ST_WAIT && xfer_done && cur.kind == hsc_pkg::STEP_READ_ID) begin
      unique case (cur.addr)
        hsc_pkg::OFS_CHIP_KIND_ID:    chip_kind <= xfer_rdata; // [R10]
        hsc_pkg::OFS_PRODUCT_ID_LOW:  product_identifier[7:0] <= xfer_rdata;
        hsc_pkg::OFS_PRODUCT_ID_HIGH: product_identifier[15:8] <= xfer_rdata;
        default: begin
          product_grade_field    <= xfer_rdata[7:4];
          silicon_revision_field <= xfer_rdata[3:0];
        end
      endcase
    end
  end

  // Ready is the go-ahead for link and oscillator setup; it drops on every new start. [R2] [R3]
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done      <= 1'b0;
      ready     <= 1'b0;
      fail      <= 1'b0;
      fail_code <= hsc_pkg::FAIL_NONE;
    end else begin
      done <= 1'b0;
      if (state == ST_IDLE && start) begin
        done      <= (decode_mode == hsc_pkg::DECODE_ILLEGAL);
        ready     <= 1'b0;
        fail      <= (decode_mode == hsc_pkg::DECODE_ILLEGAL);
        fail_code <= (decode_mode == hsc_pkg::DECODE_ILLEGAL) ?
                     hsc_pkg::FAIL_BAD_MODE : hsc_pkg::FAIL_NONE;
      end else if (state == ST_WAIT && xfer_done && poll_kind && !poll_pass && poll_last) begin
        done      <= 1'b1;
        fail      <= 1'b1; // [R20]
        fail_code <= (cur.kind == hsc_pkg::STEP_POLL_BOOT) ?
                     hsc_pkg::FAIL_BOOT : hsc_pkg::FAIL_LOCK;
      end else if ((state == ST_WAIT && xfer_done && !poll_kind &&
                    step_idx == hsc_pkg::IDX_LAST) ||
                   (state == ST_ISSUE && !xfer_start && step_idx == hsc_pkg::IDX_LAST)) begin
        done  <= 1'b1;
        ready <= 1'b1; // [R2]
      end
    end
  end

  hsc_spi_xfer #(
    .HALF_DIV (SCLK_HALF)
  ) u_xfer (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .start     (xfer_start),
    .read_op   (xfer_read),
    .addr      (cur.addr),
    .wdata     (xfer_wdata),
    .four_wire (four_wire_on),
    .busy      (xfer_busy),
    .done      (xfer_done),
    .rdata     (xfer_rdata),
    .spi_sclk  (spi_sclk),
    .spi_cs_n  (spi_cs_n),
    .sdio_in   (sdio_in),
    .sdio_out  (sdio_out),
    .sdio_oe_n (sdio_oe_n),
    .spi_sdo   (spi_sdo)
  );

  wire_mode_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R5]
    xfer_start && step_idx == hsc_pkg::IDX_WIRE_MODE |->
      cur.addr == 15'h0000 && xfer_wdata == 8'h18 && fw_want)
    else $error("Wire mode write malformed or not requested.");

  cal_reset_pair_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R6]
    state == ST_WAIT && xfer_done && step_idx == hsc_pkg::IDX_CAL_RESET |=>
      xfer_start && cur.addr == 15'h00d2 && xfer_wdata == 8'hd2)
    else $error("Calibration reset not released right after it was set.");

  nvm_load_value_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R8]
    xfer_start && !xfer_read && cur.addr == 15'h0604 |-> xfer_wdata == 8'h01)
    else $error("Nonvolatile load written with wrong value.");

  boot_pass_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R9]
    state == ST_WAIT && xfer_done && cur.kind == hsc_pkg::STEP_POLL_BOOT && !xfer_rdata[1]
      |=> step_idx == $past(step_idx))
    else $error("Sequence moved past boot poll without pass bit.");

  cal_after_lock_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R18]
    xfer_start && step_idx == hsc_pkg::IDX_CAL_EN |-> lock_seen && xfer_wdata == 8'h20)
    else $error("Calibration factors enabled without confirmed lock.");

  decode_last_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R19]
    state == ST_WAIT && xfer_done && cur.kind == hsc_pkg::STEP_DECODE |=> done && ready && !busy)
    else $error("Decode write did not end the sequence.");

  poll_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R20]
    poll_cnt < 16'(MAX_POLLS))
    else $error("Poll count passed its bound.");

  ready_clean_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R2]
    ready |-> !fail && !busy)
    else $error("Ready shown with failure or while busy.");

  done_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R1]
    done |=> !done)
    else $error("Done held longer than one cycle.");

endmodule

// ---- hdl/hsc_pkg.sv ----
package hsc_pkg;

  // Clock and serial timing.
  localparam int CLK_PERIOD_NS    = 20;
  localparam int SCLK_PERIOD_NS   = 100;
  localparam int SCLK_HALF_CYCLES = (SCLK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POLL_GAP_NS      = 10000;
  localparam int POLL_GAP_CYCLES  = POLL_GAP_NS / CLK_PERIOD_NS;
  localparam int MAX_POLLS        = 1000;

  // Serial frame layout: one direction bit, address, one data byte.
  localparam int ADDR_W  = 15;
  localparam int DATA_W  = 8;
  localparam int FRAME_W = 1 + ADDR_W + DATA_W;
  localparam int HEAD_W  = 1 + ADDR_W;

  // Device register offsets.
  localparam logic [14:0] OFS_SERIAL_PORT_CONFIG = 15'h0000;
  localparam logic [14:0] OFS_CHIP_KIND_ID       = 15'h0003;
  localparam logic [14:0] OFS_PRODUCT_ID_LOW     = 15'h0004;
  localparam logic [14:0] OFS_PRODUCT_ID_HIGH    = 15'h0005;
  localparam logic [14:0] OFS_GRADE_AND_REVISION = 15'h0006;
  localparam logic [14:0] OFS_CONVERTER_BIAS     = 15'h0040;
  localparam logic [14:0] OFS_REFERENCE_ENABLE   = 15'h0058;
  localparam logic [14:0] OFS_CLOCK_RECEIVER     = 15'h0080;
  localparam logic [14:0] OFS_LOCK_LOOP_POWER    = 15'h0090;
  localparam logic [14:0] OFS_LOCK_LOOP_ENABLE   = 15'h0091;
  localparam logic [14:0] OFS_LOCK_LOOP_STATE    = 15'h0092;
  localparam logic [14:0] OFS_ANALOG_PARAM       = 15'h009e;
  localparam logic [14:0] OFS_CAL_REG_RESET      = 15'h00d2;
  localparam logic [14:0] OFS_CAL_FACTOR_ENABLE  = 15'h00e8;
  localparam logic [14:0] OFS_OUTPUT_DECODE      = 15'h0152;
  localparam logic [14:0] OFS_NVM_LOAD_AND_PASS  = 15'h0604;
  localparam logic [14:0] OFS_NVM_CONFIG_A       = 15'h0606;
  localparam logic [14:0] OFS_NVM_CONFIG_B       = 15'h0607;

  // Values written during bring-up.
  localparam logic [7:0] VAL_FOUR_WIRE      = 8'h18;
  localparam logic [7:0] VAL_CAL_RESET_ON   = 8'h52;
  localparam logic [7:0] VAL_CAL_RESET_OFF  = 8'hd2;
  localparam logic [7:0] VAL_NVM_CONFIG_A   = 8'h02;
  localparam logic [7:0] VAL_NVM_CONFIG_B   = 8'h00;
  localparam logic [7:0] VAL_NVM_LOAD       = 8'h01;
  localparam logic [7:0] VAL_REFERENCE_ON   = 8'h03;
  localparam logic [7:0] VAL_LOOP_POWER_UP  = 8'h1e;
  localparam logic [7:0] VAL_CLOCK_RX_ON    = 8'h00;
  localparam logic [7:0] VAL_BIAS_ON        = 8'h00;
  localparam logic [7:0] VAL_ANALOG_PARAM   = 8'h85;
  localparam logic [7:0] VAL_LOOP_ENABLE    = 8'he9;
  localparam logic [7:0] VAL_CAL_FACTORS_ON = 8'h20;

  // Status bit positions and decode field.
  localparam int BOOT_PASS_BIT = 1;
  localparam int LOOP_LOCK_BIT = 0;
  localparam logic [1:0] DECODE_ILLEGAL = 2'h3;

  // Step indices of the sequence.
  localparam logic [4:0] IDX_WIRE_MODE = 5'h00;
  localparam logic [4:0] IDX_CAL_RESET = 5'h01;
  localparam logic [4:0] IDX_ID_FIRST  = 5'h06;
  localparam logic [4:0] IDX_ID_LAST   = 5'h09;
  localparam logic [4:0] IDX_CAL_EN    = 5'h12;
  localparam logic [4:0] IDX_LAST      = 5'h13;

  // Failure codes.
  localparam logic [1:0] FAIL_NONE     = 2'h0;
  localparam logic [1:0] FAIL_BOOT     = 2'h1;
  localparam logic [1:0] FAIL_LOCK     = 2'h2;
  localparam logic [1:0] FAIL_BAD_MODE = 2'h3;

  typedef enum logic [2:0] {
    STEP_WRITE,
    STEP_READ_ID,
    STEP_POLL_BOOT,
    STEP_POLL_LOCK,
    STEP_DECODE
  } hsc_kind_type;

  typedef struct packed {
    hsc_kind_type kind;
    logic [14:0]  addr;
    logic [7:0]   data;
  } hsc_step_type;

endpackage

// ---- hdl/hsc_spi_xfer.sv ----
`timescale 1ns/1ps
module hsc_spi_xfer #(
  parameter int HALF_DIV = hsc_pkg::SCLK_HALF_CYCLES
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Transfer request
  input  wire logic        start,
  input  wire logic        read_op,
  input  wire logic [14:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        four_wire,
  output logic             busy,
  output logic             done,
  output logic [7:0]       rdata,
  // Serial port pins
  output logic             spi_sclk,
  output logic             spi_cs_n,
  input  wire logic        sdio_in,
  output logic             sdio_out,
  output logic             sdio_oe_n,
  input  wire logic        spi_sdo
);

  logic [15:0] div_cnt;
  logic        tick;
  logic [4:0]  bit_cnt;
  logic [23:0] shifter;
  logic        rd_flag;

  assign tick     = busy && (div_cnt == 16'(HALF_DIV - 1));
  assign sdio_out = shifter[hsc_pkg::FRAME_W - 1];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 16'h0000;
    end else if (!busy || tick) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  // Data leaves on the falling edge and is sampled by both ends on the rising edge.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy      <= 1'b0;
      done      <= 1'b0;
      spi_sclk  <= 1'b0;
      spi_cs_n  <= 1'b1;
      sdio_oe_n <= 1'b1;
      bit_cnt   <= 5'h00;
      shifter   <= 24'h00_0000;
      rd_flag   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy && start) begin
        busy      <= 1'b1;
        spi_cs_n  <= 1'b0;
        spi_sclk  <= 1'b0;
        sdio_oe_n <= 1'b0;
        bit_cnt   <= 5'h00;
        rd_flag   <= read_op;
        shifter   <= {read_op, addr, read_op ? 8'h00 : wdata};
      end else if (tick && !spi_sclk) begin
        spi_sclk <= 1'b1;
      end else if (tick) begin
        spi_sclk <= 1'b0;
        bit_cnt  <= bit_cnt + 5'h01;
        shifter  <= {shifter[22:0], 1'b0};
        // In three-wire reads the pin is handed to the device for the data byte. [R5]
        if (bit_cnt == 5'(hsc_pkg::HEAD_W - 1) && rd_flag && !four_wire) begin
          sdio_oe_n <= 1'b1;
        end
        if (bit_cnt == 5'(hsc_pkg::FRAME_W - 1)) begin
          busy      <= 1'b0;
          done      <= 1'b1;
          spi_cs_n  <= 1'b1;
          sdio_oe_n <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (tick && !spi_sclk && rd_flag && bit_cnt >= 5'(hsc_pkg::HEAD_W)) begin
      rdata <= {rdata[6:0], four_wire ? spi_sdo : sdio_in}; // [R5]
    end
  end

  cs_frames_clock_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R5]
    spi_sclk |-> !spi_cs_n)
    else $error("Serial clock high outside a frame.");

endmodule

// ---- test/hsc_dev_model.sv ----
`timescale 1ns/1ps
module hsc_dev_model #(
  parameter logic [31:0] IDS = 32'h5a3c_c7a1 // Arbitrary identity values.
) (
  // Bench controls
  input  wire logic   sys_clk,
  input  wire logic   rst_n,
  input  wire logic   boot_ok,
  input  wire logic   lock_ok,
  // Serial port
  input  wire logic   spi_sclk,
  input  wire logic   spi_cs_n,
  input  wire logic   sdio_out,
  input  wire logic   sdio_oe_n,
  output logic        sdio_in,
  output logic        spi_sdo,
  // Write log
  output logic [23:0] frame,
  output int          wr_count
);
  logic [7:0]  regs [0:2047];
  logic [23:0] sh;
  logic [7:0]  rd;
  logic        drv = 0, dq = 0, loaded, rdop, fw;
  int          cnt = 0, pc;
  // A released line toggles, so a host sampling it by mistake never sees a steady value.
  assign sdio_in = sdio_oe_n ? dq : sdio_out;
  assign spi_sdo = fw ? dq : ~dq;
  assign fw = regs[0] == 8'h18;
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      foreach (regs[i]) regs[i] = 8'h00;
      {regs[3], regs[5], regs[4], regs[6]} = IDS;
      loaded = 0;
      pc = 0;
    end
    if (spi_cs_n) cnt = 0;
    if (spi_cs_n) drv = 0;
    if (!drv) dq = ~dq;
  end
  always @(posedge spi_sclk) if (!spi_cs_n) begin
    sh = {sh[22:0], sdio_in};
    cnt++;
    if (cnt == 16) begin
      rdop = sh[15];
      rd = regs[sh[10:0]];
      if (rdop && sh[10:0] == 11'h604) rd[1] = loaded & boot_ok & pc[0];
      if (rdop && sh[10:0] == 11'h092) rd[0] = (regs[11'h091] == 8'he9) & lock_ok & pc[0];
      pc += rdop;
    end
    if (cnt == 24 && !rdop) begin
      if (sh[18:8] == 11'h604) loaded = sh[0];
      if (!(sh[18:8] inside {[11'h003:11'h006], 11'h092})) regs[sh[18:8]] = sh[7:0];
      frame = sh;
      wr_count++;
    end
  end
  always @(negedge spi_sclk) begin
    drv = rdop && cnt >= 16 && cnt < 24;
    if (drv) dq = rd[23-cnt];
  end
endmodule

// ---- test/hsc_startup_host_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end
module hsc_startup_host_tb;
  localparam logic [31:0] IDS = 32'h5a3c_c7a1; // Arbitrary identity values.
  localparam logic [23:0] SEQ [0:13] = '{24'h00_0018, 24'h00_d252, 24'h00_d2d2, 24'h06_0602,
    24'h06_0700, 24'h06_0401, 24'h00_5803, 24'h00_901e, 24'h00_8000, 24'h00_4000,
    24'h00_9e85, 24'h00_91e9, 24'h00_e820, 24'h01_5200};
  logic        sys_clk = 0, rst_n = 0, start = 0, four_wire_req = 0, read_id_req = 0;
  logic        boot_ok = 1, lock_ok = 1, busy, done, ready, fail;
  logic        spi_sclk, spi_cs_n, sdio_in, sdio_out, sdio_oe_n, spi_sdo;
  logic [1:0]  decode_mode = 0, fail_code;
  logic [7:0]  chip_kind;
  logic [15:0] product_identifier;
  logic [3:0]  product_grade_field, silicon_revision_field;
  logic [23:0] frame, ew, wq [$];
  logic [36:0] es, sq [$];
  int          wr_count, err_count = 0, check_count = 0, cyc = 0, seed = 55009;
  wire logic [31:0] ids = {chip_kind, product_identifier, product_grade_field,
                           silicon_revision_field};
  hsc_startup_host #(.MAX_POLLS(4), .POLL_GAP(4), .SCLK_HALF(1)) hsc_startup_host_inst (
    .sys_clk, .rst_n, .start, .four_wire_req, .read_id_req, .decode_mode, .busy, .done, .ready,
    .fail, .fail_code, .chip_kind, .product_identifier, .product_grade_field,
    .silicon_revision_field, .spi_sclk, .spi_cs_n, .sdio_in, .sdio_out, .sdio_oe_n, .spi_sdo);
  hsc_dev_model #(.IDS(IDS)) hsc_dev_model_inst (.sys_clk, .rst_n, .boot_ok, .lock_ok,
    .spi_sclk, .spi_cs_n, .sdio_out, .sdio_oe_n, .sdio_in, .spi_sdo, .frame, .wr_count);
  initial forever #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    err_count += (cyc == 30000);
    if (cyc == 30000) report_and_stop();
  end
  always @(wr_count) begin
    // The frame and the count reach the bench through separate ports, so let both settle.
    #1;
    ew = wq.pop_front();
    `CHK(frame, ew)
  end
  always @(posedge sys_clk) if (done === 1'b1) begin
    es = sq.pop_front();
    `CHK({ready, fail, fail_code}, es[3:0])
    if (es[36]) `CHK(ids, es[35:4])
  end
  task automatic run(input logic fw, rid, input logic [1:0] m, input logic b, l);
    int n;
    n = (m == 3) ? 0 : !b ? 6 : !l ? 12 : 14;
    for (int i = fw ? 0 : 1; i < n; i++) wq.push_back(SEQ[i] | 24'(i == 13 ? m : 2'h0));
    sq.push_back({rid && m != 3, IDS, (m == 3) ? 4'h7 : !b ? 4'h5 : !l ? 4'h6 : 4'h8});
    @(posedge sys_clk) rst_n <= 0;
    @(posedge sys_clk) rst_n <= 1;
    boot_ok <= b;
    lock_ok <= l;
    four_wire_req <= fw;
    read_id_req <= rid;
    decode_mode <= m;
    start <= 1;
    @(posedge sys_clk) start <= 0;
    #1 if (m != 3) `CHK(busy, 1'b1)
    while (done !== 1'b1) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
    `CHK(wq.size() + sq.size(), 0)
    $display("test done: mode %0d four-wire %0d ids %0d", m, fw, rid);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1;
    run(1, 1, 0, 1, 1);
    run(0, 0, 1, 1, 1);
    run(1'($random(seed)), 1'($random(seed)), 2, 1, 1);
    run(0, 1, 3, 1, 1);
    run(1, 1, 1, 0, 1);
    run(0, 0, 2, 1, 0);
    report_and_stop();
  end
endmodule
